// >>> bench/dma_event_asserts.sv
// concurrent checks on the event controller top ports
`timescale 1ns/10ps
`default_nettype none
module dma_event_asserts #(
  parameter QD = 16
) (
  input wire REF_CLK,
  input wire SYS_RST,
  input wire HSEL,
  input wire [1:0] HTRANS,
  input wire HREADY,
  input wire HREADYOUT,
  input wire HRESP,
  input wire [31:0] HRDATA,
  input wire FAB_CMD_VALID,
  input wire FAB_CMD_WRITE,
  input wire [31:0] FAB_CMD_ADDR,
  input wire [127:0] FAB_CMD_WDATA,
  input wire [2:0] FAB_CMD_PRIO,
  input wire [1:0] FAB_CMD_ENGINE,
  input wire FAB_CMD_READY
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  wire acc = HSEL && HTRANS[1] && HREADY;
  property p_okay;
    HRESP == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
  property p_wait_one;
    acc |=> !HREADYOUT ##1 HREADYOUT;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait state not one cycle");
  property p_wait_cause;
    !HREADYOUT |-> $past(acc);
  endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("wait state without transfer");
  // read data may only move when a transfer completes
  property p_rdata_hold;
    $changed(HRDATA) |-> !$past(HREADYOUT);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved early");
  property p_cmd_hold;
    FAB_CMD_VALID && !FAB_CMD_READY |=> FAB_CMD_VALID && $stable(FAB_CMD_ADDR)
      && $stable(FAB_CMD_WRITE) && $stable(FAB_CMD_WDATA) && $stable(FAB_CMD_ENGINE)
      && $stable(FAB_CMD_PRIO);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command dropped");
  property p_rd_nodata;
    FAB_CMD_VALID && !FAB_CMD_WRITE |-> FAB_CMD_WDATA == 128'h0;
  endproperty
  a_rd_nodata: assert property (p_rd_nodata) else $error("read carries data");
  property p_beat_align;
    FAB_CMD_VALID |-> FAB_CMD_ADDR[3:0] == 4'h0;
  endproperty
  a_beat_align: assert property (p_beat_align) else $error("beat misaligned");
  property p_reset_idle;
    disable iff (1'b0) SYS_RST |=> !FAB_CMD_VALID && HREADYOUT && FAB_CMD_PRIO == 3'h0;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle in reset");
  c_wr: cover property (FAB_CMD_VALID && FAB_CMD_READY && FAB_CMD_WRITE);
  c_rd: cover property (FAB_CMD_VALID && FAB_CMD_READY && !FAB_CMD_WRITE);
  c_stall: cover property (FAB_CMD_VALID && !FAB_CMD_READY);
endmodule
bind dma_event_dataflow_priority dma_event_asserts #(.QD(QD)) u_chk (.REF_CLK, .SYS_RST,
  .HSEL, .HTRANS, .HREADY, .HREADYOUT, .HRESP, .HRDATA, .FAB_CMD_VALID, .FAB_CMD_WRITE,
  .FAB_CMD_ADDR, .FAB_CMD_WDATA, .FAB_CMD_PRIO, .FAB_CMD_ENGINE, .FAB_CMD_READY);
`default_nettype wire

// >>> bench/fabric_endpoint.sv
// fabric endpoint model: takes commands, returns read beats in order
`timescale 1ns/10ps
`default_nettype none
module fabric_endpoint (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [31:0] cmd_addr,
  input wire logic [127:0] cmd_wdata,
  input wire logic [2:0] cmd_prio,
  input wire logic [1:0] cmd_engine,
  output logic cmd_ready,
  output logic rd_valid,
  output logic [1:0] rd_engine,
  output logic [127:0] rd_data,
  output int writes,
  output logic [127:0] last_wdata,
  output logic [31:0] last_addr,
  output logic [2:0] last_prio,
  output logic [1:0] last_engine
);
  logic [33:0] q[$];
  logic [33:0] e;
  logic [1:0] slow;
  // a slow endpoint refuses every other cycle
  assign cmd_ready = !(stall && slow[0]);
  always @(posedge clk) begin
    slow <= slow + 2'h1;
    rd_valid <= 1'b0;
    // idle data lines keep toggling so stale beats never look valid
    rd_data <= ~rd_data;
    if (rst) begin
      q.delete();
      writes <= 0;
      slow <= 2'h0;
      rd_data <= 128'h0;
    end else begin
      if (cmd_valid && cmd_ready) begin
        last_prio <= cmd_prio;
        last_engine <= cmd_engine;
        if (cmd_write) begin
          writes <= writes + 1;
          last_wdata <= cmd_wdata;
          last_addr <= cmd_addr;
        end else begin
          q.push_back({cmd_engine, cmd_addr});
        end
      end
      // one global order keeps every engine's order too
      if (q.size() > 0 && !(stall && slow[1])) begin
        e = q.pop_front();
        rd_valid <= 1'b1;
        rd_engine <= e[33:32];
        rd_data <= {4{e[31:0]}};
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the event controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  logic clk, rst, hsel, hwrite, hreadyout, hresp, stall, fv, fw, frdy, rv;
  logic [1:0] htrans, fe, re, le;
  logic [2:0] hsize, fp, lp;
  logic [31:0] haddr, hwdata, hrdata, fa, r, la;
  logic [127:0] fwd, rdd, lwd;
  logic [63:0] pev;
  logic [3:0] qev;
  int mismatches, checks_done, wn;
  dma_event_dataflow_priority u_dma_event_dataflow_priority (.REF_CLK(clk), .SYS_RST(rst),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .PERIPH_EVENT(pev), .QUICK_EVENT(qev), .FAB_CMD_VALID(fv),
    .FAB_CMD_WRITE(fw), .FAB_CMD_ADDR(fa), .FAB_CMD_WDATA(fwd), .FAB_CMD_PRIO(fp),
    .FAB_CMD_ENGINE(fe), .FAB_CMD_READY(frdy), .FAB_RD_VALID(rv), .FAB_RD_ENGINE(re),
    .FAB_RD_DATA(rdd));
  fabric_endpoint u_fabric_endpoint (.clk(clk), .rst(rst), .stall(stall), .cmd_valid(fv),
    .cmd_write(fw), .cmd_addr(fa), .cmd_wdata(fwd), .cmd_prio(fp), .cmd_engine(fe),
    .cmd_ready(frdy), .rd_valid(rv), .rd_engine(re), .rd_data(rdd), .writes(wn),
    .last_wdata(lwd), .last_addr(la), .last_prio(lp), .last_engine(le));
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(r, e)
  endtask
  task automatic poll(input logic [31:0] a, input logic [31:0] e);
    int n;
    n = 0;
    bus(1'b0, a, 32'h0);
    while (r !== e && n < 60) begin
      bus(1'b0, a, 32'h0);
      n++;
    end
    `CHK(r, e)
  endtask
  task automatic set_wr(input logic [31:0] s, o, sa, da, c);
    bus(1'b1, 32'h1000 + s * 32'h10, o);
    bus(1'b1, 32'h1004 + s * 32'h10, sa);
    bus(1'b1, 32'h1008 + s * 32'h10, da);
    bus(1'b1, 32'h100C + s * 32'h10, c);
  endtask
  task automatic wait_wr(input int n);
    int k;
    k = 0;
    while (wn < n && k < 400) begin
      @(posedge clk);
      k++;
    end
    `CHK(wn, n)
  endtask
  // clears the low pending word first so each shot sees only its own low-word codes
  task automatic fire(input logic [63:0] p, input logic [3:0] q, input logic [31:0] pe,
    input int n);
    bus(1'b1, 32'h030, 32'hFFFFFFFF);
    pev <= p;
    qev <= q;
    @(posedge clk);
    pev <= 64'h0;
    qev <= 4'h0;
    poll(32'h028, pe);
    wait_wr(n);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
    pev = 64'h0;
    qev = 4'h0;
    stall = 1'b0;
    mismatches = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(32'h064, 32'h0);
    chk(32'h028, 32'h0);
    chk(32'h050, 32'h0);
    chk(32'h0F0, 32'h0);
    $display("test reset done");
    stall <= 1'b1;
    bus(1'b1, 32'h050, 32'h800);
    bus(1'b1, 32'h064, 32'h140);
    set_wr(5, 32'h3800, 32'h100, 32'h200, 32'h20);
    bus(1'b1, 32'h010, 32'h20);
    poll(32'h028, 32'h8);
    chk(32'h01C, 32'h0);
    chk(32'h010, 32'h0);
    wait_wr(2);
    `CHK(le, 2'h2)
    `CHK(lp, 3'h5)
    `CHK(lwd, {4{32'h110}})
    `CHK(la, 32'h210)
    $display("test early done");
    stall <= 1'b0;
    set_wr(6, 32'h28000, 32'h300, 32'h400, 32'h10);
    fire(64'h40, 4'h0, 32'h0, 3);
    poll(32'h02C, 32'h100);
    $display("test normal done");
    set_wr(7, 32'h0, 32'h0, 32'h0, 32'h0);
    bus(1'b1, 32'h010, 32'h80);
    poll(32'h010, 32'h0);
    chk(32'h01C, 32'h80);
    set_wr(8, 32'h9000, 32'h1, 32'h0, 32'h0);
    fire(64'h0, 4'h0, 32'h0, 3);
    bus(1'b1, 32'h010, 32'h100);
    poll(32'h028, 32'h200);
    chk(32'h01C, 32'h80);
    `CHK(wn, 3)
    // channel 7 is held off by its queued flag while two sources gather
    bus(1'b1, 32'h010, 32'h80);
    fire(64'h80, 4'h0, 32'h0, 3);
    bus(1'b1, 32'h038, 32'h80);
    poll(32'h000, 32'h0);
    chk(32'h010, 32'h80);
    chk(32'h01C, 32'h80);
    $display("test null dummy done");
    set_wr(64, 32'h1800, 32'h500, 32'h600, 32'h10);
    fire(64'h0, 4'h1, 32'h2, 4);
    set_wr(9, 32'h4800, 32'h700, 32'h710, 32'h10);
    set_wr(10, 32'h5800, 32'h800, 32'h810, 32'h10);
    set_wr(65, 32'h6800, 32'h900, 32'h910, 32'h10);
    fire(64'h600, 4'h2, 32'h70, 7);
    `CHK(lwd, {4{32'h900}})
    fire(64'h600, 4'h0, 32'h30, 9);
    `CHK(lwd, {4{32'h800}})
    $display("test priority done");
    set_wr(11, 32'h40C000, 32'hA00, 32'hA10, 32'h10);
    set_wr(12, 32'hD800, 32'hB00, 32'hB10, 32'h10);
    fire(64'h800, 4'h0, 32'h3000, 11);
    `CHK(lwd, {4{32'hB00}})
    `CHK(la, 32'hB10)
    $display("test chain done");
    wrap_up();
  end
endmodule
`default_nettype wire

// >>> core/dma_event_consts.vh
// constants for the event dataflow controller and its transfer engines
`ifndef DMA_EVENT_CONSTS_VH
`define DMA_EVENT_CONSTS_VH
`define BUS_BYTES 16
`define BEAT_SHIFT 4
`define BEAT_ROUND 17'h0000F
`define BURST_BYTES 64
`define BUF_SMALL 128
`define BUF_LARGE 256
`define SLOTS_FIRST 2
`define SLOTS_REST 4
`define QUEUE_DEPTH 16
`define SET_TOTAL 272
`define SIZE_WORD 3'h2
`define MEM_BIT 12
`define OPT_TCC_LSB 12
`define OPT_EARLY 11
`define OPT_CHAIN 22
`define W_OPT 2'h0
`define W_SRC 2'h1
`define W_DST 2'h2
`define W_CNT 2'h3
`define SRC_PERIPH 2'h0
`define SRC_CHAIN 2'h1
`define SRC_MANUAL 2'h2
`define SRC_QUICK 2'h3
`define RST_PRIO 3'h0
`define A_EVT_LO 13'h0000
`define A_EVT_HI 13'h0004
`define A_CHN_LO 13'h0008
`define A_CHN_HI 13'h000C
`define A_MAN_LO 13'h0010
`define A_MAN_HI 13'h0014
`define A_QTRIG 13'h0018
`define A_QUE_LO 13'h001C
`define A_QUE_HI 13'h0020
`define A_QQUE 13'h0024
`define A_PEND_LO 13'h0028
`define A_PEND_HI 13'h002C
`define A_PCLR_LO 13'h0030
`define A_PCLR_HI 13'h0034
`define A_QCLR_LO 13'h0038
`define A_QCLR_HI 13'h003C
`define A_QCLR_Q 13'h0040
`define A_QSEL0 13'h0050
`define A_QSEL1 13'h0054
`define A_QSEL2 13'h0058
`define A_QSEL3 13'h005C
`define A_QQSEL 13'h0060
`define A_FPRIO 13'h0064
`endif

// >>> core/dma_event_dataflow_priority.v
// event latching, prioritisation, queueing and job submission to four engines
`timescale 1ns/10ps
`default_nettype none
`include "dma_event_consts.vh"
module dma_event_dataflow_priority #(
  parameter QD = `QUEUE_DEPTH
) (
  input wire REF_CLK,
  input wire SYS_RST,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  input wire [63:0] PERIPH_EVENT,
  input wire [3:0] QUICK_EVENT,
  output reg FAB_CMD_VALID,
  output reg FAB_CMD_WRITE,
  output reg [31:0] FAB_CMD_ADDR,
  output reg [127:0] FAB_CMD_WDATA,
  output reg [2:0] FAB_CMD_PRIO,
  output reg [1:0] FAB_CMD_ENGINE,
  input wire FAB_CMD_READY,
  input wire FAB_RD_VALID,
  input wire [1:0] FAB_RD_ENGINE,
  input wire [127:0] FAB_RD_DATA
);
localparam QPW = $clog2(QD);
integer i;
integer j;
integer k;
integer m;

function [6:0] first_one;
  input [63:0] v;
  integer n;
  begin
    first_one = 7'h00;
    for (n = 63; n >= 0; n = n - 1) begin
      if (v[n]) begin
        first_one = {1'b1, n[5:0]};
      end
    end
  end
endfunction

function [63:0] bit64;
  input [5:0] n;
  begin
    bit64 = 64'h1 << n;
  end
endfunction

reg [63:0] event_latch;
reg [63:0] chain_trigger_flags;
reg [63:0] manual_trigger_flags;
reg [63:0] queued_flags;
reg [63:0] completion_pending;
reg [3:0] quick_trigger_flags;
reg [3:0] quick_queued_flags;
reg [127:0] queue_select;
reg [7:0] quick_queue_select;
reg [11:0] fabric_priority;
reg [31:0] setting_memory [0:`SET_TOTAL-1];
reg ph_act;
reg ph_write;
reg ph_word;
reg [12:0] ph_addr;
reg [31:0] rd_val;

// selection among pending, not yet queued events
wire [63:0] trig = event_latch | chain_trigger_flags | manual_trigger_flags;
wire [6:0] dma_pick = first_one(trig & ~queued_flags);
wire [6:0] qk_pick = first_one({60'h0, quick_trigger_flags & ~quick_queued_flags});
wire sel_valid = dma_pick[6] | qk_pick[6];
wire sel_quick = ~dma_pick[6];
wire [5:0] sel_idx = sel_quick ? qk_pick[5:0] : dma_pick[5:0];
wire [1:0] sel_src = sel_quick ? `SRC_QUICK :
  event_latch[sel_idx] ? `SRC_PERIPH :
  chain_trigger_flags[sel_idx] ? `SRC_CHAIN : `SRC_MANUAL;
wire [1:0] sel_q = sel_quick ? quick_queue_select[{sel_idx[1:0], 1'b0} +: 2] :
  queue_select[{sel_idx, 1'b0} +: 2];
wire [8:0] sel_entry = {sel_src, sel_quick, sel_idx};
wire [63:0] sel_bit = bit64(sel_idx);

reg [8:0] q_mem [0:4*QD-1];
reg [QPW-1:0] q_wp [0:3];
reg [QPW-1:0] q_rp [0:3];
reg [QPW:0] q_cnt [0:3];
wire [3:0] eng_ready;
reg deq_hit;
reg [1:0] deq_q;
reg proc_valid;
reg [8:0] proc_entry;
reg [1:0] proc_q;

always @* begin
  deq_hit = 1'b0;
  deq_q = 2'h0;
  for (i = 3; i >= 0; i = i - 1) begin
    if (q_cnt[i] != 0 && eng_ready[i] && !proc_valid) begin
      deq_hit = 1'b1;
      deq_q = i[1:0];
    end
  end
end

wire bypass = sel_valid && q_cnt[sel_q] == 0 && eng_ready[sel_q] &&
  !proc_valid && !deq_hit;
// a full queue leaves the event latched; it is retried every cycle
wire push = sel_valid && !bypass && q_cnt[sel_q] != QD;
wire taken = bypass | push;

always @(posedge REF_CLK) begin
  if (SYS_RST) begin
    for (j = 0; j < 4; j = j + 1) begin
      q_wp[j] <= {QPW{1'b0}};
      q_rp[j] <= {QPW{1'b0}};
      q_cnt[j] <= {(QPW+1){1'b0}};
    end
    proc_valid <= 1'b0;
    proc_entry <= 9'h000;
    proc_q <= 2'h0;
  end else begin
    for (j = 0; j < 4; j = j + 1) begin
      q_cnt[j] <= q_cnt[j] + {{QPW{1'b0}}, push && sel_q == j} -
        {{QPW{1'b0}}, deq_hit && deq_q == j};
    end
    if (push) begin
      q_mem[{sel_q, q_wp[sel_q]}] <= sel_entry;
      q_wp[sel_q] <= q_wp[sel_q] + 1'b1;
    end
    if (deq_hit) begin
      q_rp[deq_q] <= q_rp[deq_q] + 1'b1;
      proc_entry <= q_mem[{deq_q, q_rp[deq_q]}];
      proc_q <= deq_q;
    end else if (bypass) begin
      proc_entry <= sel_entry;
      proc_q <= sel_q;
    end
    proc_valid <= deq_hit | bypass;
  end
end

// processing stage: the set number equals {quick, index}
wire [6:0] pch = proc_entry[6:0];
wire [1:0] psrc = proc_entry[8:7];
wire [31:0] p_opt = setting_memory[{pch, `W_OPT}];
wire [31:0] p_src = setting_memory[{pch, `W_SRC}];
wire [31:0] p_dst = setting_memory[{pch, `W_DST}];
wire [31:0] p_cnt = setting_memory[{pch, `W_CNT}];
wire p_null = ~|{p_opt, p_src, p_dst, p_cnt};
wire p_dummy = !p_null && p_cnt[15:0] == 16'h0000;
wire job_go = proc_valid && !p_null && !p_dummy;
wire [5:0] p_code = p_opt[`OPT_TCC_LSB +: 6];
wire p_early = p_opt[`OPT_EARLY];
wire [63:0] pbit = bit64(pch[5:0]);
wire [63:0] code_bit = bit64(p_code);
wire pdma = proc_valid && !pch[6];
wire pqk = proc_valid && pch[6];

wire [3:0] e_done;
wire [3:0] e_early;
wire [3:0] e_chain;
wire [23:0] e_code;
wire [3:0] e_rreq;
wire [3:0] e_wreq;
wire [127:0] e_raddr;
wire [127:0] e_waddr;
wire [511:0] e_wdata;
reg [63:0] done_pend;
reg [63:0] done_chain;

always @* begin
  done_pend = 64'h0;
  done_chain = 64'h0;
  for (k = 0; k < 4; k = k + 1) begin
    if (e_done[k] && !e_early[k]) begin
      done_pend = done_pend | bit64(e_code[6*k +: 6]);
    end
    if (e_done[k] && e_chain[k]) begin
      done_chain = done_chain | bit64(e_code[6*k +: 6]);
    end
  end
end

wire sw_we = ph_act && ph_write && ph_word;
wire mem_hit = ph_addr[`MEM_BIT] && !ph_addr[11] && ph_addr[10:2] < `SET_TOTAL;
reg [63:0] sw_man;
reg [63:0] sw_pclr;
reg [63:0] sw_qclr;
reg [3:0] sw_qk;
reg [3:0] sw_qqclr;

always @* begin
  sw_man = 64'h0;
  sw_pclr = 64'h0;
  sw_qclr = 64'h0;
  sw_qk = 4'h0;
  sw_qqclr = 4'h0;
  if (sw_we) begin
    case (ph_addr)
      `A_MAN_LO: sw_man[31:0] = HWDATA;
      `A_MAN_HI: sw_man[63:32] = HWDATA;
      `A_QTRIG: sw_qk = HWDATA[3:0];
      `A_PCLR_LO: sw_pclr[31:0] = HWDATA;
      `A_PCLR_HI: sw_pclr[63:32] = HWDATA;
      `A_QCLR_LO: sw_qclr[31:0] = HWDATA;
      `A_QCLR_HI: sw_qclr[63:32] = HWDATA;
      `A_QCLR_Q: sw_qqclr = HWDATA[3:0];
      default: sw_man = 64'h0;
    endcase
  end
end

// clears come first so a set in the same cycle always survives;
// there is no halt input: latching and submission never stop
always @(posedge REF_CLK) begin
  if (SYS_RST) begin
    event_latch <= 64'h0;
    chain_trigger_flags <= 64'h0;
    manual_trigger_flags <= 64'h0;
    queued_flags <= 64'h0;
    completion_pending <= 64'h0;
    quick_trigger_flags <= 4'h0;
    quick_queued_flags <= 4'h0;
    queue_select <= 128'h0;
    quick_queue_select <= 8'h00;
    fabric_priority <= {4{`RST_PRIO}};
  end else begin
    event_latch <= (event_latch & ~((pdma && psrc == `SRC_PERIPH) ? pbit : 64'h0)) |
      PERIPH_EVENT;
    chain_trigger_flags <= (chain_trigger_flags &
      ~((pdma && psrc == `SRC_CHAIN) ? pbit : 64'h0)) | done_chain;
    manual_trigger_flags <= (manual_trigger_flags &
      ~((pdma && psrc == `SRC_MANUAL) ? pbit : 64'h0)) | sw_man;
    quick_trigger_flags <= (quick_trigger_flags & ~(pqk ? pbit[3:0] : 4'h0)) |
      QUICK_EVENT | sw_qk;
    // a null set keeps its queued flag until software clears it
    queued_flags <= (queued_flags & ~((pdma && !p_null) ? pbit : 64'h0) & ~sw_qclr) |
      ((taken && !sel_quick) ? bit64(sel_idx) : 64'h0);
    quick_queued_flags <= (quick_queued_flags & ~((pqk && !p_null) ? pbit[3:0] : 4'h0) &
      ~sw_qqclr) | ((taken && sel_quick) ? sel_bit[3:0] : 4'h0);
    completion_pending <= (completion_pending & ~sw_pclr) |
      ((job_go && p_early) ? code_bit : 64'h0) |
      ((proc_valid && p_dummy) ? code_bit : 64'h0) | done_pend;
    if (sw_we) begin
      case (ph_addr)
        `A_QSEL0: queue_select[31:0] <= HWDATA;
        `A_QSEL1: queue_select[63:32] <= HWDATA;
        `A_QSEL2: queue_select[95:64] <= HWDATA;
        `A_QSEL3: queue_select[127:96] <= HWDATA;
        `A_QQSEL: quick_queue_select <= HWDATA[7:0];
        `A_FPRIO: fabric_priority <= HWDATA[11:0];
        default: fabric_priority <= fabric_priority;
      endcase
    end
  end
end

// contents survive reset and start undefined; software must fill a set first
always @(posedge REF_CLK) begin
  if (sw_we && mem_hit) begin
    setting_memory[ph_addr[10:2]] <= HWDATA;
  end
end

always @* begin
  rd_val = 32'h0;
  if (mem_hit) begin
    rd_val = setting_memory[ph_addr[10:2]];
  end else begin
    case (ph_addr)
      `A_EVT_LO: rd_val = event_latch[31:0];
      `A_EVT_HI: rd_val = event_latch[63:32];
      `A_CHN_LO: rd_val = chain_trigger_flags[31:0];
      `A_CHN_HI: rd_val = chain_trigger_flags[63:32];
      `A_MAN_LO: rd_val = manual_trigger_flags[31:0];
      `A_MAN_HI: rd_val = manual_trigger_flags[63:32];
      `A_QTRIG: rd_val = {28'h0, quick_trigger_flags};
      `A_QUE_LO: rd_val = queued_flags[31:0];
      `A_QUE_HI: rd_val = queued_flags[63:32];
      `A_QQUE: rd_val = {28'h0, quick_queued_flags};
      `A_PEND_LO: rd_val = completion_pending[31:0];
      `A_PEND_HI: rd_val = completion_pending[63:32];
      `A_QSEL0: rd_val = queue_select[31:0];
      `A_QSEL1: rd_val = queue_select[63:32];
      `A_QSEL2: rd_val = queue_select[95:64];
      `A_QSEL3: rd_val = queue_select[127:96];
      `A_QQSEL: rd_val = {24'h0, quick_queue_select};
      `A_FPRIO: rd_val = {20'h0, fabric_priority};
      default: rd_val = 32'h0;
    endcase
  end
end

// one wait state on every transfer keeps read data on a flip-flop
always @(posedge REF_CLK) begin
  if (SYS_RST) begin
    HRDATA <= 32'h0;
    HREADYOUT <= 1'b1;
    HRESP <= 1'b0;
    ph_act <= 1'b0;
    ph_write <= 1'b0;
    ph_word <= 1'b0;
    ph_addr <= 13'h0000;
  end else begin
    ph_act <= 1'b0;
    if (ph_act) begin
      HRDATA <= rd_val;
      HREADYOUT <= 1'b1;
    end else if (HSEL && HTRANS[1] && HREADY) begin
      ph_act <= 1'b1;
      ph_write <= HWRITE;
      ph_word <= HSIZE == `SIZE_WORD;
      ph_addr <= HADDR[12:0];
      HREADYOUT <= 1'b0;
    end
  end
end

// fabric port: lowest priority value wins, ties to the lowest engine
reg arb_hit;
reg arb_wr;
reg [1:0] arb_eng;
reg [2:0] arb_pri;
always @* begin
  arb_hit = 1'b0;
  arb_wr = 1'b0;
  arb_eng = 2'h0;
  arb_pri = 3'h7;
  for (m = 3; m >= 0; m = m - 1) begin
    if ((e_rreq[m] | e_wreq[m]) && (!arb_hit || fabric_priority[3*m +: 3] <= arb_pri)) begin
      arb_hit = 1'b1;
      arb_eng = m[1:0];
      arb_pri = fabric_priority[3*m +: 3];
      arb_wr = e_wreq[m];
    end
  end
end
wire arb_load = arb_hit && (!FAB_CMD_VALID || FAB_CMD_READY);

always @(posedge REF_CLK) begin
  if (SYS_RST) begin
    FAB_CMD_VALID <= 1'b0;
    FAB_CMD_WRITE <= 1'b0;
    FAB_CMD_ADDR <= 32'h0;
    FAB_CMD_WDATA <= 128'h0;
    FAB_CMD_PRIO <= 3'h0;
    FAB_CMD_ENGINE <= 2'h0;
  end else begin
    if (FAB_CMD_VALID && FAB_CMD_READY) begin
      FAB_CMD_VALID <= 1'b0;
    end
    if (arb_load) begin
      FAB_CMD_VALID <= 1'b1;
      FAB_CMD_WRITE <= arb_wr;
      FAB_CMD_ADDR <= arb_wr ? e_waddr[{arb_eng, 5'h00} +: 32] : e_raddr[{arb_eng, 5'h00} +: 32];
      FAB_CMD_WDATA <= arb_wr ? e_wdata[{arb_eng, 7'h00} +: 128] : 128'h0;
      FAB_CMD_PRIO <= arb_pri;
      FAB_CMD_ENGINE <= arb_eng;
    end
  end
end

genvar g;
generate
  for (g = 0; g < 4; g = g + 1) begin : eng
    transfer_engine #(
      .BUF_BYTES(g < 2 ? `BUF_SMALL : `BUF_LARGE),
      .SLOTS(g == 0 ? `SLOTS_FIRST : `SLOTS_REST)
    ) u_eng (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .job_valid(job_go && proc_q == g),
      .job_ready(eng_ready[g]),
      .job_src(p_src),
      .job_dst(p_dst),
      .job_bytes(p_cnt[15:0]),
      .job_code(p_code),
      .job_early(p_early),
      .job_chain(p_opt[`OPT_CHAIN]),
      .rd_req(e_rreq[g]),
      .rd_addr(e_raddr[32*g +: 32]),
      .rd_ack(arb_load && !arb_wr && arb_eng == g),
      .rd_valid(FAB_RD_VALID && FAB_RD_ENGINE == g),
      .rd_data(FAB_RD_DATA),
      .wr_req(e_wreq[g]),
      .wr_addr(e_waddr[32*g +: 32]),
      .wr_data(e_wdata[128*g +: 128]),
      .wr_ack(arb_load && arb_wr && arb_eng == g),
      .done(e_done[g]),
      .done_code(e_code[6*g +: 6]),
      .done_early(e_early[g]),
      .done_chain(e_chain[g])
    );
  end
endgenerate

endmodule
`default_nettype wire

// >>> core/transfer_engine.v
// transfer engine: program set, source active set, destination slots, data buffer
`timescale 1ns/10ps
`default_nettype none
`include "dma_event_consts.vh"
module transfer_engine #(
  parameter BUF_BYTES = `BUF_SMALL,
  parameter SLOTS = `SLOTS_FIRST
) (
  input wire clk,
  input wire rst,
  input wire job_valid,
  output wire job_ready,
  input wire [31:0] job_src,
  input wire [31:0] job_dst,
  input wire [15:0] job_bytes,
  input wire [5:0] job_code,
  input wire job_early,
  input wire job_chain,
  output wire rd_req,
  output wire [31:0] rd_addr,
  input wire rd_ack,
  input wire rd_valid,
  input wire [127:0] rd_data,
  output wire wr_req,
  output wire [31:0] wr_addr,
  output wire [127:0] wr_data,
  input wire wr_ack,
  output reg done,
  output reg [5:0] done_code,
  output reg done_early,
  output reg done_chain
);
localparam BW = BUF_BYTES / `BUS_BYTES;
localparam PW = $clog2(BW);
localparam SW = $clog2(SLOTS);
localparam [12:0] BB = `BURST_BYTES / `BUS_BYTES;
reg prog_valid;
reg [31:0] prog_src;
reg [31:0] prog_dst;
reg [12:0] prog_beats;
reg [7:0] prog_info;
reg [31:0] src_addr;
reg [12:0] src_left;
reg [31:0] s_dst [0:SLOTS-1];
reg [12:0] s_beats [0:SLOTS-1];
reg [7:0] s_info [0:SLOTS-1];
reg [SW-1:0] s_head;
reg [SW-1:0] s_tail;
reg [SW:0] s_count;
reg [127:0] buf_mem [0:BW-1];
reg [PW-1:0] b_wp;
reg [PW-1:0] b_rp;
reg [PW:0] b_fill;
reg [PW:0] b_out;
reg wr_act;
reg [31:0] wr_cur;
reg [12:0] wr_left;
wire [16:0] bsum = {1'b0, job_bytes} + `BEAT_ROUND;
wire [16:0] beats = bsum >> `BEAT_SHIFT;
// both the source set and a destination slot must be free
wire start = prog_valid && src_left == 13'h0000 && s_count < SLOTS;
wire issue = rd_req && rd_ack;
wire pop = wr_req && wr_ack;
wire fin = pop && wr_left == 13'h0001;
// writing may start on one burst of data, not the whole job
wire [12:0] need = (wr_left < BB) ? wr_left : BB;
assign job_ready = !prog_valid;
// reads reserve buffer room, so returned data can never overflow it
assign rd_req = src_left != 13'h0000 && (b_fill + b_out) < BW;
assign rd_addr = src_addr;
assign wr_req = wr_act && b_fill >= need;
assign wr_addr = wr_cur;
assign wr_data = buf_mem[b_rp];
always @(posedge clk) begin
  if (rst) begin
    prog_valid <= 1'b0;
    src_left <= 13'h0000;
    src_addr <= 32'h0;
    s_head <= {SW{1'b0}};
    s_tail <= {SW{1'b0}};
    s_count <= {(SW+1){1'b0}};
    b_wp <= {PW{1'b0}};
    b_rp <= {PW{1'b0}};
    b_fill <= {(PW+1){1'b0}};
    b_out <= {(PW+1){1'b0}};
    wr_act <= 1'b0;
    wr_cur <= 32'h0;
    wr_left <= 13'h0000;
    done <= 1'b0;
    done_code <= 6'h00;
    done_early <= 1'b0;
    done_chain <= 1'b0;
  end else begin
    done <= 1'b0;
    if (job_valid && !prog_valid) begin
      prog_valid <= 1'b1;
      prog_src <= job_src;
      prog_dst <= job_dst;
      prog_beats <= beats[12:0];
      prog_info <= {job_chain, job_early, job_code};
    end else if (start) begin
      prog_valid <= 1'b0;
    end
    if (start) begin
      src_addr <= prog_src;
      src_left <= prog_beats;
      s_dst[s_tail] <= prog_dst;
      s_beats[s_tail] <= prog_beats;
      s_info[s_tail] <= prog_info;
      s_tail <= s_tail + 1'b1;
    end else if (issue) begin
      src_addr <= src_addr + `BUS_BYTES;
      src_left <= src_left - 13'h0001;
    end
    if (rd_valid) begin
      buf_mem[b_wp] <= rd_data;
      b_wp <= b_wp + 1'b1;
    end
    b_out <= b_out + {{PW{1'b0}}, issue} - {{PW{1'b0}}, rd_valid};
    b_fill <= b_fill + {{PW{1'b0}}, rd_valid} - {{PW{1'b0}}, pop};
    s_count <= s_count + {{SW{1'b0}}, start} - {{SW{1'b0}}, fin};
    if (!wr_act && s_count != 0) begin
      wr_act <= 1'b1;
      wr_cur <= s_dst[s_head];
      wr_left <= s_beats[s_head];
    end else if (pop) begin
      b_rp <= b_rp + 1'b1;
      wr_cur <= wr_cur + `BUS_BYTES;
      wr_left <= wr_left - 13'h0001;
      if (fin) begin
        wr_act <= 1'b0;
        s_head <= s_head + 1'b1;
        done <= 1'b1;
        {done_chain, done_early, done_code} <= s_info[s_head];
      end
    end
  end
end
endmodule
`default_nettype wire
